// ==== design/baud_rate_generator.sv ====
// Baud rate generator: APB register slave plus prescaled free-running rate timer
//
// The implementer's own choices: register access over APB and the address map.
`default_nettype none

module baud_rate_generator
    import rate_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Receiver status in
    input  wire logic        receiver_idle_flag,
    // Rate outputs to the transmit and receive sequencers
    output logic             rate_tick,
    output logic             prescale_tick,
    output logic             sync_mode,
    output logic             wide_divisor_select,
    output logic             high_speed_select
);

    // Register state
    logic [7:0] divisor_low_byte_q;
    logic [7:0] divisor_low_byte_d;
    logic [7:0] divisor_high_byte_q;
    logic [7:0] divisor_high_byte_d;
    rate_cfg_s  cfg_q;
    rate_cfg_s  cfg_d;
    apb_resp_s  resp_q;
    apb_resp_s  resp_d;
    logic       divisor_written;

    // Timer state
    logic [PRE_WIDTH-1:0]   pre_q;
    logic [PRE_WIDTH-1:0]   pre_d;
    logic [TIMER_WIDTH-1:0] timer_q;
    logic [TIMER_WIDTH-1:0] timer_d;
    logic                   rate_tick_q;
    logic                   rate_tick_d;
    logic                   prescale_tick_q;
    logic                   prescale_tick_d;
    logic [PRE_WIDTH-1:0]   pre_last;
    logic [TIMER_WIDTH-1:0] divisor_n;

    // Bus phases
    logic setup_phase;
    logic write_take;
    logic addr_mapped;

    // Reads and writes share one answer cycle, so the slave never adds wait states
    assign setup_phase = psel && !penable;
    // Write lands only on the edge that completes the access
    assign write_take  = psel && penable && resp_q.pready && pwrite;
    assign addr_mapped = (paddr == OFS_DIVISOR_LOW) || (paddr == OFS_DIVISOR_HIGH) ||
                         (paddr == OFS_BAUD_CONTROL) || (paddr == OFS_TX_STATUS_CTRL);

    // The receive-idle bit is live status, not a stored bit: a write to that position is
    // dropped, and a read shows the level seen in the setup cycle

    // APB answer: decoded in setup, presented in the first access cycle (no wait states)
    always_comb begin
        resp_d = '0;
        if (setup_phase) begin
            resp_d.pready  = 1'b1;
            resp_d.pslverr = !addr_mapped;
            if (!pwrite) begin
                case (paddr)
                    OFS_DIVISOR_LOW:    resp_d.prdata[7:0] = divisor_low_byte_q;
                    OFS_DIVISOR_HIGH:   resp_d.prdata[7:0] = divisor_high_byte_q;
                    OFS_BAUD_CONTROL: begin
                        resp_d.prdata[BIT_RECEIVER_IDLE] = receiver_idle_flag;
                        resp_d.prdata[BIT_WIDE_DIVISOR]  = cfg_q.wide_divisor_select;
                    end
                    OFS_TX_STATUS_CTRL: begin
                        resp_d.prdata[BIT_SYNC_MODE]  = cfg_q.sync_mode;
                        resp_d.prdata[BIT_HIGH_SPEED] = cfg_q.high_speed_select;
                    end
                    default:            resp_d.prdata = '0;
                endcase
            end
        end
    end

    // Register writes; only byte lane 0 carries data, other lanes are dropped
    always_comb begin
        divisor_low_byte_d  = divisor_low_byte_q;
        divisor_high_byte_d = divisor_high_byte_q;
        cfg_d               = cfg_q;
        divisor_written     = 1'b0;
        if (write_take && pstrb[0]) begin
            case (paddr)
                OFS_DIVISOR_LOW: begin
                    divisor_low_byte_d = pwdata[7:0];
                    divisor_written    = 1'b1;
                end
                OFS_DIVISOR_HIGH: begin
                    divisor_high_byte_d = pwdata[7:0];
                    divisor_written     = 1'b1;
                end
                OFS_BAUD_CONTROL:   cfg_d.wide_divisor_select = pwdata[BIT_WIDE_DIVISOR];
                OFS_TX_STATUS_CTRL: begin
                    cfg_d.sync_mode         = pwdata[BIT_SYNC_MODE];
                    cfg_d.high_speed_select = pwdata[BIT_HIGH_SPEED];
                end
                default:            cfg_d = cfg_q;
            endcase
        end
    end

    // Register group flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            divisor_low_byte_q  <= RST_DIVISOR_BYTE;
            divisor_high_byte_q <= RST_DIVISOR_BYTE;
            cfg_q               <= RST_CFG;
            resp_q              <= '0;
        end else begin
            divisor_low_byte_q  <= divisor_low_byte_d;
            divisor_high_byte_q <= divisor_high_byte_d;
            cfg_q               <= cfg_d;
            resp_q              <= resp_d;
        end
    end

    // Multiplier select; sync mode looks past the high-speed bit entirely
    always_comb begin
        if (cfg_q.sync_mode) begin
            pre_last = PRE_LAST_X4;
        end else begin
            case ({cfg_q.wide_divisor_select, cfg_q.high_speed_select})
                2'b00:   pre_last = PRE_LAST_X64;
                2'b01:   pre_last = PRE_LAST_X16;
                2'b10:   pre_last = PRE_LAST_X16;
                default: pre_last = PRE_LAST_X4;
            endcase
        end
    end

    // Limitation: the two divisor bytes land one at a time and each write restarts the
    // count, so the rate is only right once the second byte is in; software that needs
    // a clean switch writes the high byte first and the low byte last

    // In 8-bit mode the high byte is ignored rather than cleared, so software keeps it
    assign divisor_n = cfg_q.wide_divisor_select ? {divisor_high_byte_q, divisor_low_byte_q}
                                                 : {8'h00, divisor_low_byte_q};

    // Trade-off: one prescaler shared by all modes costs a six-bit counter, but keeps
    // prescale_tick on a fixed grid that the sequencers can use for sampling
    // Prescaler and timer next state: period is multiplier times (n+1) clocks
    always_comb begin
        pre_d           = pre_q;
        timer_d         = timer_q;
        rate_tick_d     = 1'b0;
        prescale_tick_d = 1'b0;
        if (divisor_written) begin
            pre_d   = '0;
            timer_d = '0;
        end else if (pre_q >= pre_last) begin
            // >= guards a multiplier shrinking while the prescaler is past the new end
            pre_d           = '0;
            prescale_tick_d = 1'b1;
            if (timer_q >= divisor_n) begin
                timer_d     = '0;
                rate_tick_d = 1'b1;
            end else begin
                timer_d = timer_q + 16'h0001;
            end
        end else begin
            pre_d = pre_q + 6'h01;
        end
    end

    // Ticks are registered so both rate outputs come straight from flops, at the price
    // of one clock of latency after the terminal count
    // Timer flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pre_q           <= '0;
            timer_q         <= '0;
            rate_tick_q     <= 1'b0;
            prescale_tick_q <= 1'b0;
        end else begin
            pre_q           <= pre_d;
            timer_q         <= timer_d;
            rate_tick_q     <= rate_tick_d;
            prescale_tick_q <= prescale_tick_d;
        end
    end

    // Outputs straight from flops
    assign pready              = resp_q.pready;
    assign pslverr             = resp_q.pslverr;
    assign prdata              = resp_q.prdata;
    assign rate_tick           = rate_tick_q;
    assign prescale_tick       = prescale_tick_q;
    assign sync_mode           = cfg_q.sync_mode;
    assign wide_divisor_select = cfg_q.wide_divisor_select;
    assign high_speed_select   = cfg_q.high_speed_select;

endmodule // baud_rate_generator

`default_nettype wire

// ==== shared/rate_timer_pkg.sv ====
// Package: register map, field positions and constants for the rate timer block
`default_nettype none

package rate_timer_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] OFS_DIVISOR_LOW      = 8'h00;
    localparam logic [7:0] OFS_DIVISOR_HIGH     = 8'h04;
    localparam logic [7:0] OFS_BAUD_CONTROL     = 8'h08;
    localparam logic [7:0] OFS_TX_STATUS_CTRL   = 8'h0C;

    // Field positions in baud_control_reg
    localparam int unsigned BIT_RECEIVER_IDLE   = 6;
    localparam int unsigned BIT_WIDE_DIVISOR    = 3;
    // Field positions in transmit_status_control_reg
    localparam int unsigned BIT_SYNC_MODE       = 4;
    localparam int unsigned BIT_HIGH_SPEED      = 2;

    // Reset values
    localparam logic [7:0] RST_DIVISOR_BYTE     = 8'h00;
    localparam logic       RST_CFG_BIT          = 1'b0;

    // Divisor multipliers, expressed as prescaler terminal counts (multiplier - 1)
    localparam int unsigned PRE_WIDTH           = 6;
    localparam logic [5:0] PRE_LAST_X64         = 6'h3F;
    localparam logic [5:0] PRE_LAST_X16         = 6'h0F;
    localparam logic [5:0] PRE_LAST_X4          = 6'h03;

    localparam int unsigned TIMER_WIDTH         = 16;

    // Configuration bits that steer the divider
    typedef struct packed {
        logic sync_mode;
        logic wide_divisor_select;
        logic high_speed_select;
    } rate_cfg_s;

    localparam rate_cfg_s RST_CFG = '{sync_mode: 1'b0, wide_divisor_select: 1'b0, high_speed_select: 1'b0};

    // APB response carried as one group
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_resp_s;

endpackage

`default_nettype wire

// ==== test/baud_rate_generator_monitor.sv ====
// Checker: bus and rate timing assertions on the generator ports
`default_nettype none
module baud_rate_generator_monitor
    import rate_timer_pkg::*;
(
    // Clock, reset and bus
    input wire logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0]  pstrb,
    // Rate side
    input wire logic        rate_tick, prescale_tick, sync_mode, wide_divisor_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Decoded access kinds; paddr is held through the access phase
    wire mapped = paddr inside {OFS_DIVISOR_LOW, OFS_DIVISOR_HIGH, OFS_BAUD_CONTROL, OFS_TX_STATUS_CTRL};
    wire div_wr = pready && pwrite && pstrb[0] && paddr inside {OFS_DIVISOR_LOW, OFS_DIVISOR_HIGH};
    chk_ready_next: assert property (psel && !penable |=> pready) else $error("late ready");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    chk_err_map: assert property (pready |-> pslverr == !mapped) else $error("bad slverr");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray rdata");
    chk_wide_write: assert property (pready && pwrite && pstrb[0] && paddr == OFS_BAUD_CONTROL
        |=> wide_divisor_select == $past(pwdata[BIT_WIDE_DIVISOR])) else $error("wide select");
    chk_tick_align: assert property (rate_tick |-> prescale_tick) else $error("tick off grid");
    chk_tick_pulse: assert property (rate_tick |=> !rate_tick) else $error("tick held");
    chk_div_clear: assert property (div_wr |=> !rate_tick [*4]) else $error("no clear");
    chk_sync_four: assert property ((prescale_tick && sync_mode && !psel) ##1 (sync_mode && !psel) [*3]
        |=> prescale_tick) else $error("sync prescale");
    // Main scenarios reached
    cover property (div_wr);
    cover property (rate_tick && sync_mode);
    cover property (pready && pslverr);
endmodule // baud_rate_generator_monitor
bind baud_rate_generator baud_rate_generator_monitor mon (.clk_sys, .reset, .psel, .penable, .pwrite, .pready,
    .pslverr, .paddr, .pwdata, .prdata, .pstrb, .rate_tick, .prescale_tick, .sync_mode, .wide_divisor_select);
`default_nettype wire

// ==== test/baud_rate_generator_tb.sv ====
// Testbench: register access and rate period checks for the baud rate generator
`default_nettype none
module baud_rate_generator_tb import rate_timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, start_rx = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, rate_tick, prescale_tick, sync_mode, wide_divisor_select, high_speed_select;
    logic receiver_idle_flag;
    int bad_count = 0, total_checks = 0;
    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;
    baud_rate_generator dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .pslverr, .prdata, .receiver_idle_flag, .rate_tick, .prescale_tick, .sync_mode, .wide_divisor_select,
        .high_speed_select);
    serial_seq_model partner (.clk_sys, .reset, .start_rx, .rate_tick, .receiver_idle_flag);
    // One bus transfer; entered just after a rising edge, holds the request until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) bad_count++;
        // Release, then let one edge pass so a following call never re-drives psel in this time step
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Edges until the next rate tick, bounded so a dead timer cannot hang the run
    task automatic ticks(output int c);
        c = 0;
        do begin @(posedge clk_sys); c++; end while (rate_tick !== 1'b1 && c < 9000);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        int m, c;
        repeat (6) @(posedge clk_sys);
        reset <= 0;
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            apb(0, 8'(i * 4), 0, 4'hF);
            check({err, rd[30:0]}, i == 4 ? 32'h80000000 : i == 2 ? 32'h40 : 0);
        end
        apb(1, OFS_DIVISOR_HIGH, 1, 4'hF);
        apb(1, OFS_DIVISOR_HIGH, 32'h55, 4'h0);
        apb(0, OFS_DIVISOR_HIGH, 0, 4'hF);
        check(rd, 1);
        $display("test registers done");
        // Every configuration; high byte 1 is ignored in 8-bit mode
        for (int k = 0; k < 8; k++) begin
            m = k[2] ? 4 : (k[1] ^ k[0]) ? 16 : k[1] ? 4 : 64;
            m = m * (k[1] ? 259 : 3);
            apb(1, OFS_TX_STATUS_CTRL, {27'h0, k[2], 1'b0, k[0], 2'b0}, 4'hF);
            apb(1, OFS_BAUD_CONTROL, {28'h0, k[1], 3'b0}, 4'hF);
            check({sync_mode, wide_divisor_select, high_speed_select}, k[2:0]);
            apb(1, OFS_DIVISOR_LOW, 2, 4'hF);
            ticks(c);
            check(c >= m && c <= m + 2, 1);
            ticks(c);
            check(c, m);
        end
        $display("test modes done");
        start_rx <= 1;
        @(posedge clk_sys);
        start_rx <= 0;
        apb(0, OFS_BAUD_CONTROL, 0, 4'hF);
        check(rd[6], 0);
        repeat (11) ticks(c);
        apb(0, OFS_BAUD_CONTROL, 0, 4'hF);
        check(rd, 32'h48);
        $display("test idle done");
        tally_and_finish();
    end
    // Watchdog: about twice the expected run
    initial begin
        #400us;
        bad_count++;
        tally_and_finish();
    end
endmodule // baud_rate_generator_tb
`default_nettype wire

// ==== test/serial_seq_model.sv ====
// Partner model: sequencer that spends rate ticks on frames and reports receive idle
`default_nettype none
module serial_seq_model (
    // Clock, reset and frame start
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic start_rx,
    // Rate tick in, idle status out
    input  wire logic rate_tick,
    output logic      receiver_idle_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] bits_q;
    // Ten bit times per frame; busy until they are spent
    always_ff @(posedge clk_sys) begin
        if (reset) bits_q <= 4'h0;
        else if (start_rx) bits_q <= 4'hA;
        else if (rate_tick && bits_q != 4'h0) bits_q <= bits_q - 4'h1;
    end
    assign receiver_idle_flag = (bits_q == 4'h0);
endmodule // serial_seq_model
`default_nettype wire
